// >>> design/bse_pkg.sv
// constants, fields and opcodes of the bit and skip execution block
// assumes an apb master with 32-bit data and byte addressing
//
// Summary of operation
// [RULE1] clear-bit on a port forces one port bit low, flags kept
// [RULE2] set-bit on a port forces one port bit high, flags kept
// [RULE3] clear-bit on memory writes zero into one byte bit, flags kept
// [RULE4] set-bit on memory writes one into one byte bit, flags kept
// [RULE5] carry exchange swaps a port bit with carry, only carry changes
// [RULE6] output bit: exchange drives the old carry onto the pin
// [RULE7] input bit: exchange loads the sampled pin level into carry
// [RULE8] compare equal: flags from acc minus operand, skip when equal
// [RULE9] compare unequal: flags from acc minus operand, skip when different
// [RULE10] port bit test skips on low or high bit, flags kept
// [RULE11] memory bit test skips on low or high bit, flags kept
// [RULE12] acc increment sets all four flags, skips when result is zero
// [RULE13] acc decrement sets all four flags, skips when result is zero
// [RULE14] memory increment writes back, sets flags, skips on zero
// [RULE15] memory decrement writes back, sets flags, skips on zero
// [RULE16] a skip passes one word and annuls all its side effects
// [RULE17] subtract flags: carry, aux carry as borrows, overflow signed
`default_nettype none

package bse_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ACC = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_OUT = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PORT_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PORT_PIN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PC = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_MEM_ADDR = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MEM_DATA = 8'h20;

  // ---------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------
  localparam int unsigned OP_LSB = 0;
  localparam int unsigned OP_W = 5;
  localparam int unsigned BIT_LSB = 8;
  localparam int unsigned BIT_W = 3;
  localparam int unsigned IMM_LSB = 16;
  localparam int unsigned MADR_LSB = 24;
  localparam int unsigned FLG_Z = 0;
  localparam int unsigned FLG_C = 1;
  localparam int unsigned FLG_AC = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned PC_W = 16;
  localparam int unsigned PC_SKIP_BIT = 16;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [15:0] RST_PC = 16'h0000;

  typedef enum logic [OP_W-1:0] {
    OP_NOP = 5'h00,
    OP_CLR_IO = 5'h01,
    OP_SET_IO = 5'h02,
    OP_CLR_MEM = 5'h03,
    OP_SET_MEM = 5'h04,
    OP_SWAPC = 5'h05,
    OP_CEQ_IMM = 5'h06,
    OP_CEQ_MEM = 5'h07,
    OP_CNE_IMM = 5'h08,
    OP_CNE_MEM = 5'h09,
    OP_TLO_IO = 5'h0A,
    OP_THI_IO = 5'h0B,
    OP_TLO_MEM = 5'h0C,
    OP_THI_MEM = 5'h0D,
    OP_INC_ACC = 5'h0E,
    OP_DEC_ACC = 5'h0F,
    OP_INC_MEM = 5'h10,
    OP_DEC_MEM = 5'h11
  } bse_op_t;

endpackage : bse_pkg

`default_nettype wire

// >>> design/bse_alu_if.sv
// carrier between the executor and its 8-bit adder
// assumes a purely combinational adder on the far side
`default_nettype none

interface bse_alu_if;
  logic [7:0] opa;
  logic [7:0] opb;
  logic sub;
  logic [7:0] res;
  logic z;
  logic c;
  logic ac;
  logic ov;
  modport exec (output opa, output opb, output sub,
                input res, input z, input c, input ac, input ov);
  modport alu (input opa, input opb, input sub,
               output res, output z, output c, output ac, output ov);
endinterface : bse_alu_if

`default_nettype wire

// >>> design/bse_alu.sv
// 8-bit add or subtract with zero, carry, aux carry and overflow
// assumes operands are stable within the cycle; no state here
`default_nettype none

module bse_alu (
  // operand and flag carrier
  bse_alu_if.alu alu
);
  logic [7:0] b_eff;
  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    // subtraction as a plus inverted b plus one
    b_eff = alu.sub ? ~alu.opb : alu.opb;
    full = {1'b0, alu.opa} + {1'b0, b_eff} + {8'h00, alu.sub};
    low = {1'b0, alu.opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu.sub};
    alu.res = full[7:0];
    alu.z = (full[7:0] == 8'h00);
    // borrow is the inverted carry out
    alu.c = alu.sub ? ~full[8] : full[8]; // RULE17
    alu.ac = alu.sub ? ~low[4] : low[4]; // RULE17
    alu.ov = (alu.opa[7] == b_eff[7]) && (full[7] != alu.opa[7]); // RULE17
  end
endmodule : bse_alu

`default_nettype wire

// >>> design/bse_exec.sv
// bit manipulation and conditional skip executor behind an apb slave
// assumes apb3 signalling, pins synchronous to clk_i, one port
//
// The placing of the registers and the APB slave port are this design's own decisions.
`default_nettype none

module bse_exec #(
  parameter int unsigned MEM_DEPTH = 16,
  parameter int unsigned PORT_W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [bse_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // i/o port pins
  input wire logic [PORT_W-1:0] port_i,
  output logic [PORT_W-1:0] port_o,
  output logic [PORT_W-1:0] port_oe_o,
  // core status
  output logic [bse_pkg::PC_W-1:0] pc_o,
  output logic skip_o
);
  import bse_pkg::*;

  localparam int unsigned MADR_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic [3:0] flags;
    logic [PORT_W-1:0] port_out;
    logic [PORT_W-1:0] port_dir;
    logic [PC_W-1:0] pc;
    logic skip;
    logic [31:0] last_instr;
    logic [MADR_W-1:0] mem_addr;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [31:0] rdata;
    logic slverr;
  } bse_state_t;

  bse_state_t st;
  bse_state_t next_st;

  bse_alu_if alu_if ();

  bse_alu u_alu (
    .alu (alu_if.alu)
  );

  // ---------------------------------------------------------------
  // instruction fields
  // ---------------------------------------------------------------
  bse_op_t op;
  logic [BIT_W-1:0] bsel;
  logic [7:0] imm;
  logic [MADR_W-1:0] midx;
  logic [7:0] mbyte;
  logic [PORT_W-1:0] io_now;
  logic io_bit;
  logic mem_bit;
  logic apb_setup;
  logic apb_write;
  logic hit;

  assign op = bse_op_t'(pwdata_i[OP_LSB +: OP_W]);
  assign bsel = pwdata_i[BIT_LSB +: BIT_W];
  assign imm = pwdata_i[IMM_LSB +: 8];
  assign midx = pwdata_i[MADR_LSB +: MADR_W];
  assign mbyte = st.mem[midx];
  // an output bit reads back its latch, an input bit reads the pin
  assign io_now = (st.port_dir & st.port_out) | (~st.port_dir & port_i);
  assign io_bit = io_now[bsel];
  assign mem_bit = mbyte[bsel];
  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pwrite_i;

  // ---------------------------------------------------------------
  // adder operands
  // ---------------------------------------------------------------
  always_comb begin
    alu_if.opa = st.acc;
    alu_if.opb = imm;
    alu_if.sub = 1'b0;
    case (op)
      OP_CEQ_IMM, OP_CNE_IMM: begin
        alu_if.sub = 1'b1;
      end
      OP_CEQ_MEM, OP_CNE_MEM: begin
        alu_if.opb = mbyte;
        alu_if.sub = 1'b1;
      end
      OP_INC_ACC: begin
        alu_if.opb = 8'h01;
      end
      OP_DEC_ACC: begin
        alu_if.opb = 8'h01;
        alu_if.sub = 1'b1;
      end
      OP_INC_MEM: begin
        alu_if.opa = mbyte;
        alu_if.opb = 8'h01;
      end
      OP_DEC_MEM: begin
        alu_if.opa = mbyte;
        alu_if.opb = 8'h01;
        alu_if.sub = 1'b1;
      end
      default: begin
        alu_if.sub = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    hit = 1'b1;
    // read data is latched in the setup cycle, so the access needs no wait
    if (paddr_i == OFS_INSTR) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_ACC) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_FLAGS) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_PORT_OUT) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_PORT_DIR) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_PORT_PIN) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_PC) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_MEM_ADDR) begin
      hit = 1'b1;
    end else if (paddr_i == OFS_MEM_DATA) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end

    if (apb_setup) begin
      next_st.slverr = !hit;
      next_st.rdata = 32'h0000_0000;
      if (paddr_i == OFS_INSTR) begin
        next_st.rdata = st.last_instr;
      end else if (paddr_i == OFS_ACC) begin
        next_st.rdata[7:0] = st.acc;
      end else if (paddr_i == OFS_FLAGS) begin
        next_st.rdata[3:0] = st.flags;
      end else if (paddr_i == OFS_PORT_OUT) begin
        next_st.rdata[PORT_W-1:0] = st.port_out;
      end else if (paddr_i == OFS_PORT_DIR) begin
        next_st.rdata[PORT_W-1:0] = st.port_dir;
      end else if (paddr_i == OFS_PORT_PIN) begin
        next_st.rdata[PORT_W-1:0] = port_i;
      end else if (paddr_i == OFS_PC) begin
        next_st.rdata[PC_W-1:0] = st.pc;
        next_st.rdata[PC_SKIP_BIT] = st.skip;
      end else if (paddr_i == OFS_MEM_ADDR) begin
        next_st.rdata[MADR_W-1:0] = st.mem_addr;
      end else if (paddr_i == OFS_MEM_DATA) begin
        next_st.rdata[7:0] = st.mem[st.mem_addr];
      end
    end

    if (apb_write) begin
      if (paddr_i == OFS_INSTR) begin
        next_st.last_instr = pwdata_i;
        next_st.pc = st.pc + 16'h0001;
        next_st.skip = 1'b0;
        if (st.skip) begin
          // annulled word: only the program counter, last_instr and skip move
          next_st.skip = 1'b0; // RULE16
        end else begin
          case (op)
            OP_CLR_IO: begin
              next_st.port_out[bsel] = 1'b0; // RULE1
            end
            OP_SET_IO: begin
              next_st.port_out[bsel] = 1'b1; // RULE2
            end
            OP_CLR_MEM: begin
              next_st.mem[midx][bsel] = 1'b0; // RULE3
            end
            OP_SET_MEM: begin
              next_st.mem[midx][bsel] = 1'b1; // RULE4
            end
            OP_SWAPC: begin
              // on an input bit the latch takes carry too, unseen until
              // the bit is turned to output
              next_st.port_out[bsel] = st.flags[FLG_C]; // RULE6
              next_st.flags[FLG_C] = io_bit; // RULE5 RULE7
            end
            OP_CEQ_IMM, OP_CEQ_MEM: begin
              next_st.flags = {alu_if.ov, alu_if.ac, alu_if.c, alu_if.z}; // RULE8
              next_st.skip = alu_if.z; // RULE8
            end
            OP_CNE_IMM, OP_CNE_MEM: begin
              next_st.flags = {alu_if.ov, alu_if.ac, alu_if.c, alu_if.z}; // RULE9
              next_st.skip = !alu_if.z; // RULE9
            end
            OP_TLO_IO: begin
              next_st.skip = !io_bit; // RULE10
            end
            OP_THI_IO: begin
              next_st.skip = io_bit; // RULE10
            end
            OP_TLO_MEM: begin
              next_st.skip = !mem_bit; // RULE11
            end
            OP_THI_MEM: begin
              next_st.skip = mem_bit; // RULE11
            end
            OP_INC_ACC: begin
              next_st.acc = alu_if.res; // RULE12
              next_st.flags = {alu_if.ov, alu_if.ac, alu_if.c, alu_if.z}; // RULE12
              next_st.skip = alu_if.z; // RULE12
            end
            OP_DEC_ACC: begin
              next_st.acc = alu_if.res; // RULE13
              next_st.flags = {alu_if.ov, alu_if.ac, alu_if.c, alu_if.z}; // RULE13
              next_st.skip = alu_if.z; // RULE13
            end
            OP_INC_MEM: begin
              next_st.mem[midx] = alu_if.res; // RULE14
              next_st.flags = {alu_if.ov, alu_if.ac, alu_if.c, alu_if.z}; // RULE14
              next_st.skip = alu_if.z; // RULE14
            end
            OP_DEC_MEM: begin
              next_st.mem[midx] = alu_if.res; // RULE15
              next_st.flags = {alu_if.ov, alu_if.ac, alu_if.c, alu_if.z}; // RULE15
              next_st.skip = alu_if.z; // RULE15
            end
            default: begin
              // unknown codes behave as a no-operation word
              next_st.skip = 1'b0;
            end
          endcase
        end
      end else if (paddr_i == OFS_ACC) begin
        next_st.acc = pwdata_i[7:0];
      end else if (paddr_i == OFS_FLAGS) begin
        next_st.flags = pwdata_i[3:0];
      end else if (paddr_i == OFS_PORT_OUT) begin
        next_st.port_out = pwdata_i[PORT_W-1:0];
      end else if (paddr_i == OFS_PORT_DIR) begin
        next_st.port_dir = pwdata_i[PORT_W-1:0];
      end else if (paddr_i == OFS_MEM_ADDR) begin
        next_st.mem_addr = pwdata_i[MADR_W-1:0];
      end else if (paddr_i == OFS_MEM_DATA) begin
        next_st.mem[st.mem_addr] = pwdata_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.acc <= RST_ACC;
      st.flags <= RST_FLAGS;
      st.port_out <= RST_PORT[PORT_W-1:0];
      st.port_dir <= RST_PORT[PORT_W-1:0];
      st.pc <= RST_PC;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o = st.rdata;
  assign pslverr_o = st.slverr;
  assign pready_o = 1'b1;
  assign port_o = st.port_out;
  assign port_oe_o = st.port_dir;
  assign pc_o = st.pc;
  assign skip_o = st.skip;

endmodule : bse_exec

`default_nettype wire

// >>> testbench/bse_exec_properties.sv
// checker of the bit and skip executor, bound to bse_exec
// assumes zero wait apb and the instruction layout of bse_pkg
`default_nettype none
module bse_exec_properties
  import bse_pkg::*;
#(parameter int unsigned PORT_W = 8) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb and pins
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [PORT_W-1:0] port_i,
  input wire logic [PORT_W-1:0] port_o,
  input wire logic [PORT_W-1:0] port_oe_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic skip_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // properties
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic acc_e, iw, ex;
  logic [4:0] op;
  logic [2:0] b;
  logic [PORT_W-1:0] io;
  assign acc_e = psel_i && penable_i;
  assign iw = acc_e && pwrite_i && paddr_i == OFS_INSTR;
  assign ex = iw && !skip_o;
  assign op = pwdata_i[4:0];
  assign b = pwdata_i[10:8];
  // output bits read back the latch, input bits the pin
  assign io = (port_oe_o & port_o) | (~port_oe_o & port_i);
  property p_pc_step;
    iw |=> pc_o == $past(pc_o) + 16'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc not stepped");
  property p_pc_hold;
    acc_e && !iw |=> $stable(pc_o);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("pc moved");
  property p_annul;
    iw && skip_o |=> !skip_o && $stable(port_o) && $stable(port_oe_o);
  endproperty
  a_annul: assert property (p_annul) else $error("annulled word acted");
  property p_clr_io;
    ex && op == OP_CLR_IO |=> port_o == ($past(port_o) & ~(PORT_W'(1) << $past(b)));
  endproperty
  a_clr_io: assert property (p_clr_io) else $error("port bit not cleared");
  property p_set_io;
    ex && op == OP_SET_IO |=> port_o == ($past(port_o) | (PORT_W'(1) << $past(b)));
  endproperty
  a_set_io: assert property (p_set_io) else $error("port bit not set");
  property p_tst_io;
    ex && op inside {OP_TLO_IO, OP_THI_IO} |=>
      skip_o == ($past(io[b]) == $past(op == OP_THI_IO));
  endproperty
  a_tst_io: assert property (p_tst_io) else $error("port test skip wrong");
  property p_no_skip;
    ex && op inside {[5'h00:5'h05]} |=> !skip_o;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("bit op set skip");
  property p_dir;
    !(acc_e && pwrite_i && paddr_i == OFS_PORT_DIR) |=> $stable(port_oe_o);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
endmodule : bse_exec_properties
bind bse_exec bse_exec_properties #(.PORT_W(PORT_W)) i_props (.clk_i, .rst_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .port_i, .port_o,
  .port_oe_o, .pc_o, .skip_o);
`default_nettype wire

// >>> testbench/bse_exec_tb_top.sv
// random instruction stream against a bench model of bse_exec
// assumes apb byte offsets of bse_pkg and pins driven by the bench
`default_nettype none
module bse_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bse_pkg::*;
  // ----
  // bench
  // ----
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [ADDR_W-1:0] padr = '0;
  logic [31:0] pwd = '0;
  logic [31:0] prd;
  logic rdy, err, skip;
  logic [7:0] pin = '0;
  logic [7:0] pout, poe;
  logic [PC_W-1:0] pc;
  logic [32:0] q[$];
  int fails = 0;
  int checked = 0;
  int seed = 2;
  logic [7:0] m_acc, m_out, m_dir;
  logic [7:0] m_mem[16];
  logic [3:0] m_flg;
  logic [15:0] m_pc;
  logic m_skip;
  bse_exec i_dut (.clk_i, .rst_n_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .port_i(pin), .port_o(pout), .port_oe_o(poe), .pc_o(pc), .skip_o(skip));
  initial forever #2.5 clk_i = ~clk_i;
  task automatic give_verdict;
    if (fails == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    if (psel && pen && !pwr && rdy === 1'b1) begin
      checked++;
      if ({err, prd} !== q.pop_front()) begin
        fails++;
        $display("wrong value at %0t: read %h at %h", $time, {err, prd}, padr);
      end
    end
    // every write of the bench goes to a mapped register
    if (psel && pen && pwr && rdy === 1'b1) begin
      checked++;
      if (err !== 1'b0) begin
        fails++;
        $display("wrong value at %0t: write error at %h", $time, padr);
      end
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk_i);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (rdy !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      give_verdict();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : chk
  // add or borrowing subtract, returns {ov, ac, c, z, result}
  function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b,
                                      input logic s);
    logic [8:0] r;
    logic h, v;
    r = s ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    h = s ? a[3:0] < b[3:0] : ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    v = (s ? a[7] != b[7] : a[7] == b[7]) && r[7] != a[7];
    return {v, h, r[8], r[7:0] == 8'h00, r[7:0]};
  endfunction : alu
  function automatic logic [7:0] pick();
    logic [7:0] w;
    w = 8'($random(seed));
    case (w[2:0])
      3'd0: return 8'hFF;
      3'd1: return 8'h00;
      3'd2: return 8'h01;
      3'd3: return 8'h7F;
      3'd4: return 8'h80;
      default: return 8'($random(seed));
    endcase
  endfunction : pick
  task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] i,
                     input logic [3:0] ma);
    logic [7:0] io, mv;
    logic [11:0] r;
    logic sk;
    apb(1'b1, OFS_INSTR, {4'h0, ma, i, 5'h00, b, 3'h0, op});
    m_pc++;
    io = (m_dir & m_out) | (~m_dir & pin);
    mv = m_mem[ma];
    sk = 1'b0;
    r = '0;
    if (m_skip) m_skip = 1'b0;
    else begin
      case (op)
        OP_CLR_IO: m_out[b] = 1'b0;
        OP_SET_IO: m_out[b] = 1'b1;
        OP_CLR_MEM: m_mem[ma][b] = 1'b0;
        OP_SET_MEM: m_mem[ma][b] = 1'b1;
        OP_SWAPC: begin
          m_out[b] = m_flg[FLG_C];
          m_flg[FLG_C] = io[b];
        end
        OP_CEQ_IMM, OP_CNE_IMM: r = alu(m_acc, i, 1'b1);
        OP_CEQ_MEM, OP_CNE_MEM: r = alu(m_acc, mv, 1'b1);
        OP_TLO_IO: sk = !io[b];
        OP_THI_IO: sk = io[b];
        OP_TLO_MEM: sk = !mv[b];
        OP_THI_MEM: sk = mv[b];
        OP_INC_ACC, OP_DEC_ACC: r = alu(m_acc, 8'h01, op[0]);
        OP_INC_MEM, OP_DEC_MEM: r = alu(mv, 8'h01, op[0]);
        default: ;
      endcase
      if (op inside {[OP_CEQ_IMM:OP_CNE_MEM], [OP_INC_ACC:OP_DEC_MEM]}) begin
        m_flg = r[11:8];
        sk = r[8] ^ (op inside {OP_CNE_IMM, OP_CNE_MEM});
      end
      if (op inside {OP_INC_ACC, OP_DEC_ACC}) m_acc = r[7:0];
      if (op inside {OP_INC_MEM, OP_DEC_MEM}) m_mem[ma] = r[7:0];
      m_skip = sk;
    end
  endtask : run
  task automatic check_all(input logic [3:0] ma);
    chk(OFS_ACC, {25'h0, m_acc});
    chk(OFS_FLAGS, {29'h0, m_flg});
    chk(OFS_PORT_OUT, {25'h0, m_out});
    chk(OFS_PC, {16'h0, m_skip, m_pc});
    chk(OFS_PORT_DIR, {25'h0, m_dir});
    // the last edge was a read access, so the pins and pc are settled here
    checked++;
    if (pout !== m_out || poe !== m_dir) begin
      fails++;
      $display("wrong value at %0t: pins %h dir %h", $time, pout, poe);
    end
    checked++;
    if (pc !== m_pc || skip !== m_skip) begin
      fails++;
      $display("wrong value at %0t: pc %h skip %b", $time, pc, skip);
    end
    apb(1'b1, OFS_MEM_ADDR, {28'h0, ma});
    chk(OFS_MEM_DATA, {25'h0, m_mem[ma]});
  endtask : check_all
  initial begin
    logic [7:0] v, imm;
    logic [3:0] ma;
    m_acc = '0;
    m_out = '0;
    m_dir = '0;
    m_flg = '0;
    m_pc = '0;
    m_skip = 1'b0;
    foreach (m_mem[j]) m_mem[j] = 8'h00;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    chk(OFS_PORT_DIR, 33'h0);
    chk(8'h24, {1'b1, 32'h0});
    chk(8'h02, {1'b1, 32'h0});
    pin <= 8'h5A;
    chk(OFS_PORT_PIN, {25'h0, 8'h5A});
    // pc is read only, this write must not land
    apb(1'b1, OFS_PC, 32'h0000_0055);
    check_all(4'h0);
    for (int n = 0; n < 500; n++) begin
      v = 8'($random(seed));
      pin <= 8'($random(seed));
      ma = 4'($random(seed));
      if (v[0]) begin
        m_acc = pick();
        apb(1'b1, OFS_ACC, {24'h0, m_acc});
      end
      if (v[1]) begin
        m_flg = 4'($random(seed));
        apb(1'b1, OFS_FLAGS, {28'h0, m_flg});
      end
      if (v[2]) begin
        m_dir = 8'($random(seed));
        apb(1'b1, OFS_PORT_DIR, {24'h0, m_dir});
      end
      if (v[3]) begin
        apb(1'b1, OFS_MEM_ADDR, {28'h0, ma});
        m_mem[ma] = v[5] ? m_acc : pick();
        apb(1'b1, OFS_MEM_DATA, {24'h0, m_mem[ma]});
      end
      imm = v[4] ? m_acc : pick();
      run(5'($unsigned($random(seed)) % 19), 3'($random(seed)), imm, ma);
      check_all(ma);
    end
    give_verdict();
  end
endmodule : bse_exec_tb_top
`default_nettype wire
